// ### pinctl.sv
// port 1 / port 3 pin control with AXI4-Lite register access
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module pinctl import pinctl_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // port 1 pins
    input wire logic [7:0] port1_in,
    output logic [7:0] port1_out,
    output logic [7:0] port1_oe,
    // port 3 inputs, port 2 bit 0, analog comparator results and comparator power enable
    input wire logic port3_in1,
    input wire logic port3_in2,
    input wire logic port3_in3,
    input wire logic port2_bit0,
    input wire logic [1:0] cmp_result,
    output logic cmp_power_en,
    // port 3 outputs
    output logic port3_out4,
    output logic port3_out5,
    output logic port3_out6,
    output logic port3_out7,
    // timers and core power state
    input wire logic timer8_out,
    input wire logic timer16_out,
    output logic timer_edge_pulse,
    input wire logic stop_mode,
    input wire logic stop_recovery,
    // interrupt
    output logic irq
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            EDGE_FALL: hit = prev & ~cur;
            EDGE_RISE: hit = ~prev & cur;
            EDGE_BOTH: hit = prev ^ cur;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_hit

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] port_config_reg_r, p1_dir_r, p1_data_r, p3_mode_r, irq_edge_r;
    logic [7:0] timer8_ctrl_r, timer_common_ctrl_r, timer16_ctrl_r, p3_data_r;
    logic [N_EVENTS-1:0] status_r, enable_r, status_nxt, event_set;
    logic [7:0] awaddr_r, wr_data_r;
    logic aw_got_r, w_got_r, wr_do, wr_mapped;
    logic [31:0] rd_data;
    logic rd_mapped;

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int N_SYNC = 14;
    logic [N_SYNC-1:0] sync_raw, sync1_r, sync2_r;
    assign sync_raw = {cmp_result, port2_bit0, port3_in3, port3_in2, port3_in1, port1_in};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= sync_raw;
            sync2_r <= sync1_r;
        end
    end

    logic [7:0] p1_pins;
    logic in1_dig, in2_dig, in3_dig, p20_s;
    logic [1:0] cmp_s;
    assign p1_pins = sync2_r[7:0];
    assign in1_dig = sync2_r[8];
    assign in2_dig = sync2_r[9];
    assign in3_dig = sync2_r[10];
    assign p20_s = sync2_r[11];
    assign cmp_s = sync2_r[13:12];

    // ****************************************
    // comparators
    // ****************************************
    logic cmp_active, cmp_active_r;
    logic [1:0] cmp_hold_r;
    assign cmp_active = p3_mode_r[BIT_CMP_EN] & ~stop_mode;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_active_r <= 1'b0;
            cmp_hold_r <= 2'h0;
            cmp_power_en <= 1'b0;
        end else begin
            cmp_active_r <= cmp_active;
            cmp_power_en <= cmp_active;
            if (cmp_active_r) begin
                cmp_hold_r <= cmp_s;
            end
        end
    end

    // ****************************************
    // edge detection
    // ****************************************
    logic in1_val, in2_val, in1_prev_r, in2_prev_r, tsrc, tsrc_prev_r;
    logic [2:0] arm_r;
    assign in1_val = p3_mode_r[BIT_CMP_EN] ? cmp_hold_r[0] : in1_dig;
    assign in2_val = p3_mode_r[BIT_CMP_EN] ? cmp_hold_r[1] : in2_dig;
    assign tsrc = timer_common_ctrl_r[BIT_DEMOD_SRC] ? p20_s : in1_val;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in1_prev_r <= 1'b0;
            in2_prev_r <= 1'b0;
            tsrc_prev_r <= 1'b0;
            arm_r <= 3'h0;
        end else begin
            // no edges until synchronisers hold real levels
            arm_r <= {arm_r[1:0], 1'b1};
            in1_prev_r <= in1_val;
            in2_prev_r <= in2_val;
            tsrc_prev_r <= tsrc;
        end
    end

    logic [1:0] irq_sel, tmr_sel, logic_sel;
    logic tedge;
    assign irq_sel = irq_edge_r[BIT_IRQ_EDGE_LO +: 2];
    assign tmr_sel = timer_common_ctrl_r[BIT_LOGIC_LO +: 2];
    assign logic_sel = tmr_sel;
    assign tedge = timer_common_ctrl_r[BIT_DEMOD_MODE] & arm_r[2]
                   & edge_hit(tsrc_prev_r, tsrc, tmr_sel);
    assign event_set[EV_IN1] = arm_r[2] & edge_hit(in1_prev_r, in1_val, irq_sel);
    assign event_set[EV_IN2] = arm_r[2] & edge_hit(in2_prev_r, in2_val, irq_sel);
    assign event_set[EV_TIMER_EDGE] = tedge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_edge_pulse <= 1'b0;
        end else begin
            timer_edge_pulse <= tedge;
        end
    end

    // ****************************************
    // port 1 drivers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port1_out <= RST_BYTE;
            port1_oe <= RST_BYTE;
        end else if (port_config_reg_r[BIT_OPEN_DRAIN]) begin
            port1_out <= RST_BYTE;
            port1_oe <= p1_dir_r & ~p1_data_r;
        end else begin
            port1_out <= p1_data_r;
            port1_oe <= p1_dir_r;
        end
    end

    // ****************************************
    // port 3 outputs
    // ****************************************
    logic logic_out;
    always_comb begin
        unique case (logic_sel)
            LOGIC_AND: logic_out = timer8_out & timer16_out;
            LOGIC_OR: logic_out = timer8_out | timer16_out;
            LOGIC_NOR: logic_out = ~(timer8_out | timer16_out);
            default: logic_out = ~(timer8_out & timer16_out);
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port3_out4 <= 1'b0;
            port3_out5 <= 1'b0;
            port3_out6 <= 1'b0;
            port3_out7 <= 1'b0;
        end else begin
            // timer8 or port data on bit 4
            port3_out4 <= timer8_ctrl_r[BIT_T8_PIN_SEL] ? timer8_out : p3_data_r[4];
            port3_out5 <= timer16_ctrl_r[BIT_T16_PIN_SEL] ? timer16_out : p3_data_r[5];
            // logic output on bit 6 in transmit mode when BIT_DEMOD_SRC is set
            port3_out6 <= (!timer_common_ctrl_r[BIT_DEMOD_MODE]
                           && timer_common_ctrl_r[BIT_DEMOD_SRC]) ? logic_out : p3_data_r[6];
            port3_out7 <= p3_mode_r[BIT_CMP_EN] ? cmp_hold_r[1] : p3_data_r[7];
        end
    end

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    assign wr_do = aw_got_r & w_got_r & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 8'h00;
            wr_data_r <= 8'h00;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_got_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
            s_axi_wready <= ~w_got_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wr_data_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
            end
            if (wr_do) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case (awaddr_r)
            OFF_PORT_CONFIG, OFF_P1_DIR, OFF_P1_DATA, OFF_P3_MODE, OFF_IRQ_EDGE,
            OFF_T8_CTRL, OFF_COMMON_CTRL, OFF_T16_CTRL, OFF_P3_DATA,
            OFF_IRQ_CLEAR, OFF_IRQ_ENABLE: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    // ****************************************
    // register file
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p1_dir_r <= RST_BYTE;
            port_config_reg_r <= RST_BYTE;
            p1_data_r <= RST_BYTE;
            p3_mode_r <= RST_BYTE;
            irq_edge_r <= RST_BYTE;
            timer8_ctrl_r <= RST_BYTE;
            timer_common_ctrl_r <= RST_BYTE;
            timer16_ctrl_r <= RST_BYTE;
            p3_data_r <= RST_BYTE;
            enable_r <= '0;
        end else begin
            if (wr_do && wr_mapped && (awaddr_r != OFF_IRQ_CLEAR)) begin
                unique case (awaddr_r)
                    OFF_PORT_CONFIG: port_config_reg_r <= wr_data_r;
                    OFF_P1_DIR: p1_dir_r <= wr_data_r;
                    OFF_P1_DATA: p1_data_r <= wr_data_r;
                    OFF_P3_MODE: p3_mode_r <= wr_data_r;
                    OFF_IRQ_EDGE: irq_edge_r <= wr_data_r;
                    OFF_T8_CTRL: timer8_ctrl_r <= wr_data_r;
                    OFF_COMMON_CTRL: timer_common_ctrl_r <= wr_data_r;
                    OFF_T16_CTRL: timer16_ctrl_r <= wr_data_r;
                    OFF_P3_DATA: p3_data_r <= wr_data_r;
                    default: enable_r <= wr_data_r[N_EVENTS-1:0];
                endcase
            end
            if (stop_recovery) begin
                p1_dir_r <= RST_BYTE;
            end
        end
    end

    // ****************************************
    // interrupt status
    // ****************************************
    always_comb begin
        status_nxt = status_r;
        if (wr_do && awaddr_r == OFF_IRQ_CLEAR) begin
            status_nxt = status_r & ~wr_data_r[N_EVENTS-1:0];
        end
        status_nxt = status_nxt | event_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= '0;
            irq <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq <= |(status_nxt & enable_r);
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_mapped = 1'b1;
        unique case (s_axi_araddr)
            OFF_PORT_CONFIG, OFF_IRQ_CLEAR: rd_data = 32'h0000_0000;
            OFF_P1_DIR: rd_data[7:0] = p1_dir_r;
            OFF_P1_DATA: rd_data[7:0] = p1_data_r;
            OFF_P1_PINS: rd_data[7:0] = p1_pins;
            OFF_P3_MODE: rd_data[7:0] = p3_mode_r;
            OFF_IRQ_EDGE: rd_data[7:0] = irq_edge_r;
            OFF_T8_CTRL: rd_data[7:0] = timer8_ctrl_r;
            OFF_COMMON_CTRL: rd_data[7:0] = timer_common_ctrl_r;
            OFF_T16_CTRL: rd_data[7:0] = timer16_ctrl_r;
            OFF_P3_DATA: rd_data[7:0] = p3_data_r;
            OFF_IRQ_STATUS: rd_data[N_EVENTS-1:0] = status_r;
            OFF_IRQ_ENABLE: rd_data[N_EVENTS-1:0] = enable_r;
            OFF_P3_PINS: rd_data[5:0] = {cmp_hold_r, in3_dig, in2_val, in1_val, p20_s};
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : pinctl

// ### pinctl_pkg.sv
// constants for the port 1 / port 3 pin control block
// Operation
// - power-on reset makes port 1 all inputs
// - port 1 drivers push-pull or open-drain
// - stop-mode recovery restores port 1 to inputs
// - comparators active only when mode bit set
// - comparators: in1, in2 against two references
// - in1, in2 interrupt on selected edges
// - timer edge input from in1 or port2 bit0
// - stop mode powers down both comparators
// - timer and logic outputs routed onto port 3
// - timer8 select routes output bit 4
package pinctl_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFF_PORT_CONFIG = 8'h00;
    localparam logic [7:0] OFF_P1_DIR = 8'h04;
    localparam logic [7:0] OFF_P1_DATA = 8'h08;
    localparam logic [7:0] OFF_P1_PINS = 8'h0C;
    localparam logic [7:0] OFF_P3_MODE = 8'h10;
    localparam logic [7:0] OFF_IRQ_EDGE = 8'h14;
    localparam logic [7:0] OFF_T8_CTRL = 8'h18;
    localparam logic [7:0] OFF_COMMON_CTRL = 8'h1C;
    localparam logic [7:0] OFF_T16_CTRL = 8'h20;
    localparam logic [7:0] OFF_P3_DATA = 8'h24;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h2C;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h30;
    localparam logic [7:0] OFF_P3_PINS = 8'h34;
    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_OPEN_DRAIN = 1;
    localparam int BIT_CMP_EN = 1;
    localparam int BIT_IRQ_EDGE_LO = 6;
    localparam int BIT_T8_PIN_SEL = 0;
    localparam int BIT_T16_PIN_SEL = 0;
    localparam int BIT_DEMOD_MODE = 7;
    localparam int BIT_DEMOD_SRC = 6;
    localparam int BIT_LOGIC_LO = 4;
    localparam int EV_IN1 = 0;
    localparam int EV_IN2 = 1;
    localparam int EV_TIMER_EDGE = 2;
    localparam int N_EVENTS = 3;
    // ****************************************
    // reset values and encodings
    // ****************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] LOGIC_AND = 2'h0;
    localparam logic [1:0] LOGIC_OR = 2'h1;
    localparam logic [1:0] LOGIC_NOR = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pinctl_pkg

// ### pinctl_properties.sv
// concurrent checks on the pin control block ports
`timescale 1ns/100ps
module pinctl_properties (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins and power
    input wire logic [7:0] port1_oe,
    input wire logic stop_mode,
    input wire logic stop_recovery,
    input wire logic cmp_power_en,
    input wire logic irq
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_all_inputs: assert property ($past(!aresetn) |-> port1_oe == 8'h00 && !irq)
        else $error("port 1 driving or irq high after reset");
    a_recovery_inputs: assert property (stop_recovery |-> ##2 port1_oe == 8'h00)
        else $error("port 1 still driving after stop recovery");
    a_stop_powers_down: assert property (stop_mode |=> !cmp_power_en)
        else $error("comparators powered in stop mode");
    a_power_needs_run: assert property ($rose(cmp_power_en) |-> !$past(stop_mode))
        else $error("comparators powered up from stop");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped or changed");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_ready_drops: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write address accepted");
endmodule : pinctl_properties

bind pinctl pinctl_properties pinctl_properties_inst (.*);

// ### pin_world.sv
// far-side model: pins, comparator sources and timers
`timescale 1ns/100ps
module pin_world (
    // clock and bench levels
    input wire logic aclk,
    input wire logic [7:0] p1_pull,
    input wire logic [3:0] p3_level,
    input wire logic [1:0] cmp_level,
    input wire logic [1:0] timer_level,
    // design drive
    input wire logic [7:0] port1_out,
    input wire logic [7:0] port1_oe,
    input wire logic cmp_power_en,
    // towards the design
    output logic [7:0] port1_in,
    output logic port3_in1,
    output logic port3_in2,
    output logic port3_in3,
    output logic port2_bit0,
    output logic [1:0] cmp_result,
    output logic timer8_out,
    output logic timer16_out
);
    logic [1:0] junk_r = 2'h1;
    // ****************************************
    // pin levels
    // ****************************************
    // undriven bits rest at the outside level
    assign port1_in = (port1_oe & port1_out) | (~port1_oe & p1_pull);
    always_ff @(posedge aclk) begin
        {port2_bit0, port3_in3, port3_in2, port3_in1} <= p3_level;
        {timer16_out, timer8_out} <= timer_level;
        junk_r <= ~junk_r;
    end
    always_ff @(posedge aclk) begin
        cmp_result <= cmp_power_en ? cmp_level : junk_r;
    end
endmodule : pin_world

// ### pinctl_test.sv
// self-checking bench for the pin control block
`timescale 1ns/100ps
module pinctl_test import pinctl_pkg::*; ;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, port1_in, port1_out, port1_oe, p1_pull;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0] s_axi_wstrb, p3_level;
    logic [1:0] s_axi_bresp, s_axi_rresp, cmp_result, cmp_level, timer_level, wresp, rd_r;
    logic port3_in1, port3_in2, port3_in3, port2_bit0, cmp_power_en, timer8_out, timer16_out;
    logic port3_out4, port3_out5, port3_out6, port3_out7, timer_edge_pulse;
    logic stop_mode, stop_recovery, irq;
    int n_mismatch, n_tests, seed, n_pulse, mdl[int];
    logic [7:0] offs[9] = '{OFF_P1_DIR, OFF_P1_DATA, OFF_P3_MODE, OFF_IRQ_EDGE, OFF_T8_CTRL,
        OFF_COMMON_CTRL, OFF_T16_CTRL, OFF_P3_DATA, OFF_IRQ_ENABLE};

    pinctl pinctl_inst (.*);
    pin_world pin_world_inst (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // counts timer edge pulses as they stand at each edge
    always @(posedge aclk) begin
        if (timer_edge_pulse === 1'b1) begin
            n_pulse <= n_pulse + 1;
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic ck(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : ck
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    task automatic limit(inout int n);
        n++;
        if (n > 200) begin
            n_mismatch++;
            results();
        end
    endtask : limit
    task automatic wt(input int k);
        repeat (k) @(posedge aclk);
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            limit(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                wresp = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            limit(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rd_d = s_axi_rdata;
                rd_r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end while (s_axi_arvalid || s_axi_rready);
        ck($sformatf("rdata at %h", a), exp, rd_d);
        ck("rresp", 32'(er), 32'(rd_r));
    endtask : rc
    function automatic logic lop(input int code, input logic a, input logic b);
        case (code)
            0: return a & b;
            1: return a | b;
            2: return ~(a | b);
            default: return ~(a & b);
        endcase
    endfunction : lop
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        logic [31:0] v;
        logic [7:0] e_oe, e_out;
        int st, np;
        seed = 32'h6720;
        n_mismatch = 0;
        n_tests = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0000F;
        {p1_pull, p3_level, cmp_level, timer_level, stop_mode, stop_recovery} = 18'h0;
        wt(12);
        aresetn <= 1'b1;
        wt(1);
        ck("port1_oe", 32'h0, 32'(port1_oe));
        foreach (offs[i]) begin
            rc(offs[i], 32'h0, RESP_OKAY);
            v = $random(seed);
            wr(offs[i], v);
            mdl[offs[i]] = (offs[i] == OFF_IRQ_ENABLE) ? v & ((1 << N_EVENTS) - 1) : v & 32'hFF;
        end
        foreach (offs[i]) begin
            rc(offs[i], mdl[offs[i]], RESP_OKAY);
            wr(offs[i], 32'h0);
        end
        wr(OFF_PORT_CONFIG, 32'h2);
        rc(OFF_PORT_CONFIG, 32'h0, RESP_OKAY);
        wr(8'h38, 32'hFF);
        ck("bresp", 32'(RESP_SLVERR), 32'(wresp));
        rc(8'h38, 32'h0, RESP_SLVERR);
        for (int od = 0; od < 2; od++) begin
            v = $random(seed);
            p1_pull <= v[15:8];
            wr(OFF_PORT_CONFIG, od << BIT_OPEN_DRAIN);
            wr(OFF_P1_DIR, {24'h0, v[23:16]});
            wr(OFF_P1_DATA, {24'h0, v[7:0]});
            wt(4);
            e_oe = od ? (v[23:16] & ~v[7:0]) : v[23:16];
            e_out = od ? 8'h00 : v[7:0];
            ck("port1_oe", 32'(e_oe), 32'(port1_oe));
            ck("port1_out", 32'(e_out), 32'(port1_out));
            rc(OFF_P1_PINS, 32'((e_oe & e_out) | (~e_oe & v[15:8])), RESP_OKAY);
        end
        v = $random(seed);
        p3_level <= v[3:0];
        cmp_level <= v[5:4];
        wr(OFF_P3_MODE, 1 << BIT_CMP_EN);
        wt(6);
        ck("cmp_power_en", 32'h1, 32'(cmp_power_en));
        e_out = {2'h0, v[5], v[4], v[2], v[5], v[4], v[3]};
        rc(OFF_P3_PINS, 32'(e_out), RESP_OKAY);
        ck("port3_out7", 32'(v[5]), 32'(port3_out7));
        stop_mode <= 1'b1;
        wt(1);
        cmp_level <= ~v[5:4];
        wt(6);
        ck("cmp_power_en", 32'h0, 32'(cmp_power_en));
        rc(OFF_P3_PINS, 32'(e_out), RESP_OKAY);
        stop_mode <= 1'b0;
        wr(OFF_P1_DIR, 32'hFF);
        wr(OFF_P3_MODE, 32'h0);
        stop_mode <= 1'b1;
        wt(3);
        stop_mode <= 1'b0;
        stop_recovery <= 1'b1;
        wt(1);
        stop_recovery <= 1'b0;
        wt(3);
        ck("port1_oe", 32'h0, 32'(port1_oe));
        rc(OFF_P1_DIR, 32'h0, RESP_OKAY);
        p3_level <= 4'h0;
        wt(4);
        for (int code = 0; code < 4; code++) begin
            wr(OFF_IRQ_EDGE, code << BIT_IRQ_EDGE_LO);
            wr(OFF_IRQ_ENABLE, code + 1);
            for (int lv = 1; lv >= 0; lv--) begin
                wr(OFF_IRQ_CLEAR, 32'h7);
                p3_level <= {2'h0, lv[0], lv[0]};
                wt(6);
                st = (code == 2 || code == lv) ? 3 : 0;
                rc(OFF_IRQ_STATUS, 32'(st), RESP_OKAY);
                ck("irq", 32'((st & (code + 1)) != 0), 32'(irq));
            end
        end
        wr(OFF_IRQ_ENABLE, 32'h4);
        np = n_pulse;
        for (int src = 0; src < 2; src++) begin
            wr(OFF_COMMON_CTRL, 32'h90 | (src << BIT_DEMOD_SRC));
            for (int k = 0; k < 2; k++) begin
                p3_level <= 4'h0;
                wt(4);
                wr(OFF_IRQ_CLEAR, 32'h7);
                p3_level <= k ? 4'h1 : 4'h8;
                wt(6);
                st = (src != k) ? 4 : 0;
                np += (st != 0);
                rc(OFF_IRQ_STATUS, 32'(st), RESP_OKAY);
                ck("irq", 32'(st != 0), 32'(irq));
            end
        end
        ck("timer_edge_pulse count", np, n_pulse);
        wr(OFF_T8_CTRL, 32'h1);
        wr(OFF_T16_CTRL, 32'h1);
        for (int code = 0; code < 4; code++) begin
            wr(OFF_COMMON_CTRL, 32'h40 | (code << BIT_LOGIC_LO));
            for (int t = 0; t < 4; t++) begin
                timer_level <= t[1:0];
                wt(4);
                ck("port3_out4", 32'(t[0]), 32'(port3_out4));
                ck("port3_out5", 32'(t[1]), 32'(port3_out5));
                ck("port3_out6", 32'(lop(code, t[0], t[1])), 32'(port3_out6));
            end
        end
        wr(OFF_T8_CTRL, 32'h0);
        wr(OFF_T16_CTRL, 32'h0);
        wr(OFF_COMMON_CTRL, 32'h0);
        v = $random(seed);
        wr(OFF_P3_DATA, v);
        wt(3);
        ck("port3_out", 32'(v[7:4]), 32'({port3_out7, port3_out6, port3_out5, port3_out4}));
        results();
    end
endmodule : pinctl_test
